// *** hdl/cffr_regs.vh ***
/*
  Constants of the charger fault flag block: flag bit positions, power-path
  codes and the interrupt pulse timing.
  Assumes a 100 MHz core clock.
*/
`ifndef CFFR_REGS_VH
`define CFFR_REGS_VH

`define CFFR_NFLAGS 12
`define CFFR_F_CV 0
`define CFFR_F_DONE 1
`define CFFR_F_IINLIM 2
`define CFFR_F_DYNAMIC_POWER_PATH_LOOP 3
`define CFFR_F_VINDPM 4
`define CFFR_F_THERM 5
`define CFFR_F_PGOOD 6
`define CFFR_F_OVP 7
`define CFFR_F_OCP 8
`define CFFR_F_UVLO 9
`define CFFR_F_COLD 10
`define CFFR_F_COOL 11

`define CFFR_RAIL_MODE_NORMAL 2'h0
`define CFFR_SRC_INPUT 2'h0
`define CFFR_SRC_BATTERY 2'h1
`define CFFR_SRC_OPEN 2'h2

`define CFFR_TMR_RUN 2'h0
`define CFFR_TMR_PAUSE 2'h1
`define CFFR_TMR_RESET 2'h2

`define CFFR_CLK_MHZ 100
`define CFFR_INT_PULSE_US 128
`define CFFR_INT_PULSE_CYC (`CFFR_INT_PULSE_US * `CFFR_CLK_MHZ)

`endif

// *** hdl/cffr_int_pulse.v ***
/*
  Interrupt pulse stretcher: a one-cycle request drives the open-drain
  line low for a fixed time.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cffr_regs.vh"

module cffr_int_pulse (
  input wire clk,
  input wire resetn,
  input wire trigger,
  output wire int_out,
  output wire int_oe,
  output wire busy
);

  reg [13:0] cnt_r;

  // The macro is a 32-bit product; only its low 14 bits are loaded.
  localparam [31:0] PULSE_LEN = `CFFR_INT_PULSE_CYC;

  // A request during a running pulse restarts it, so events never vanish.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 14'h0000;
    end else if (trigger) begin
      cnt_r <= PULSE_LEN[13:0];
    end else if (cnt_r != 14'h0000) begin
      cnt_r <= cnt_r - 14'h0001;
    end
  end

  assign int_oe = (cnt_r != 14'h0000);
  assign int_out = 1'b0;
  assign busy = int_oe;

endmodule // cffr_int_pulse

`default_nettype wire

// *** hdl/cffr_flags.v ***
/*
  Fault and status flag logic of a single-cell charge manager: sticky
  flags, interrupt pulses, charger enable, safety-timer and rail source.
  Assumes status inputs are asynchronous analogue comparator outputs and
  that flag reads and mask bits come from the serial register logic on
  this clock.
*/
// Operation
// - Power-path loop edge flags; charging continues reduced
// - Active loops double timer when stretch enabled
// - Loops keep rail on input unless supplement
// - Input bad stops charge; good needs mode 00
// - Input-good interrupt both edges; first edge suppressed if input good with UVLO at startup
// - Overvoltage: flag, pause, reset timer, battery rail
// - Battery-only overcurrent: flag, disable, disconnect battery
// - Cold: flag, pause charge and timer
// - Each interrupt starts a fixed low pulse; one during a pulse restarts it
// - Masked conditions never pulse, even after unmask
// - Flags stay until read; read clears
`timescale 1ns/1ps
`default_nettype none
`include "cffr_regs.vh"

module cffr_flags (
  input wire clk,
  input wire resetn,
  input wire cv_active,
  input wire charge_done,
  input wire iinlim_active,
  input wire dynamic_power_path_loop_active,
  input wire vindpm_active,
  input wire therm_active,
  input wire input_good,
  input wire input_ovp,
  input wire bat_ocp,
  input wire bat_uvlo,
  input wire ts_cold,
  input wire ts_cool,
  input wire supplement_cond,
  input wire recharge_reached,
  input wire charge_en_cfg,
  input wire timer_stretch_en,
  input wire [1:0] rail_mode,
  input wire [11:0] int_mask,
  input wire [11:0] flag_read,
  output reg [11:0] flags,
  output reg input_good_state,
  output reg charger_enable,
  output reg [1:0] safety_timer_ctrl,
  output reg safety_timer_double,
  output reg [1:0] system_rail_source_select,
  output wire int_out,
  output wire int_oe
);

  wire [11:0] raw_w;
  reg [11:0] sync1_r;
  reg [11:0] sync2_r;
  reg [11:0] prev_r;
  reg [11:0] flags_nxt;
  reg [11:0] fire_nxt;
  reg primed_r;
  reg [1:0] warm_r;
  reg suppress_pg_r;
  reg done_hold_r;
  reg done_hold_nxt;
  reg en_prev_r;
  reg pg_prev_r;
  reg int_req_r;
  wire [11:0] rise_w;
  wire [11:0] fall_w;
  wire any_loop_w;
  wire battery_only_w;

  assign raw_w = {ts_cool, ts_cold, bat_uvlo, bat_ocp, input_ovp,
                  input_good, therm_active, vindpm_active, dynamic_power_path_loop_active,
                  iinlim_active, charge_done, cv_active};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
    end else begin
      sync1_r <= raw_w;
      sync2_r <= sync1_r;
    end
  end

  assign rise_w = sync2_r & ~prev_r;
  assign fall_w = ~sync2_r & prev_r;
  assign any_loop_w = sync2_r[`CFFR_F_IINLIM] | sync2_r[`CFFR_F_DYNAMIC_POWER_PATH_LOOP] |
                      sync2_r[`CFFR_F_VINDPM] | sync2_r[`CFFR_F_THERM];
  assign battery_only_w = ~sync2_r[`CFFR_F_PGOOD];

  // Flag set and interrupt decision; set wins over a same-cycle read.
  always @* begin
    flags_nxt = (flags & ~flag_read) | rise_w;
    if (fall_w[`CFFR_F_PGOOD]) begin
      flags_nxt[`CFFR_F_PGOOD] = 1'b1;
    end
    if (!primed_r) begin
      flags_nxt = flags;
    end
    // Only a fresh trigger, unmasked, with the flag clear sends a pulse.
    fire_nxt = (rise_w | (fall_w & (12'h001 << `CFFR_F_PGOOD)))
               & ~int_mask & ~flags;
    if (suppress_pg_r || !primed_r) begin
      fire_nxt[`CFFR_F_PGOOD] = 1'b0;
    end
    if (!primed_r) begin
      fire_nxt = 12'h000;
    end
  end

  // The first valid synchronised sample only primes the edge history, so
  // conditions present at power-up count as levels, not edges. The
  // synchroniser needs two edges before its output is valid at all.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warm_r <= 2'h0;
    end else begin
      warm_r <= {warm_r[0], 1'b1};
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 12'h000;
      primed_r <= 1'b0;
      flags <= 12'h000;
      int_req_r <= 1'b0;
      suppress_pg_r <= 1'b0;
    end else begin
      prev_r <= sync2_r;
      primed_r <= warm_r[1];
      flags <= flags_nxt;
      int_req_r <= |fire_nxt;
      if (!primed_r) begin
        suppress_pg_r <= sync2_r[`CFFR_F_PGOOD] &
                         sync2_r[`CFFR_F_UVLO];
      end else if (rise_w[`CFFR_F_PGOOD] || fall_w[`CFFR_F_PGOOD]) begin
        suppress_pg_r <= 1'b0;
      end
    end
  end

  // Termination hold: released by input or enable toggle, or recharge.
  always @* begin
    done_hold_nxt = done_hold_r;
    if (rise_w[`CFFR_F_DONE]) begin
      done_hold_nxt = 1'b1;
    end else if ((sync2_r[`CFFR_F_PGOOD] != pg_prev_r) ||
                 (charge_en_cfg != en_prev_r) || recharge_reached) begin
      done_hold_nxt = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_hold_r <= 1'b0;
      en_prev_r <= 1'b0;
      pg_prev_r <= 1'b0;
      input_good_state <= 1'b0;
      charger_enable <= 1'b0;
      safety_timer_ctrl <= `CFFR_TMR_RESET;
      safety_timer_double <= 1'b0;
      system_rail_source_select <= `CFFR_SRC_BATTERY;
    end else begin
      done_hold_r <= done_hold_nxt;
      en_prev_r <= charge_en_cfg;
      pg_prev_r <= sync2_r[`CFFR_F_PGOOD];
      input_good_state <= sync2_r[`CFFR_F_PGOOD];
      // Loop, cool and undervoltage states leave charging enabled.
      charger_enable <= charge_en_cfg & sync2_r[`CFFR_F_PGOOD] &
                        ~sync2_r[`CFFR_F_OVP] & ~sync2_r[`CFFR_F_COLD] &
                        ~done_hold_nxt &
                        ~(sync2_r[`CFFR_F_OCP] & battery_only_w);
      if (!sync2_r[`CFFR_F_PGOOD] || sync2_r[`CFFR_F_OVP] ||
          done_hold_nxt) begin
        safety_timer_ctrl <= `CFFR_TMR_RESET;
      end else if (sync2_r[`CFFR_F_COLD]) begin
        safety_timer_ctrl <= `CFFR_TMR_PAUSE;
      end else begin
        safety_timer_ctrl <= `CFFR_TMR_RUN;
      end
      safety_timer_double <= timer_stretch_en &
                             (any_loop_w | sync2_r[`CFFR_F_COOL]);
      if (sync2_r[`CFFR_F_OCP] && battery_only_w) begin
        system_rail_source_select <= `CFFR_SRC_OPEN;
      end else if (sync2_r[`CFFR_F_OVP]) begin
        system_rail_source_select <= `CFFR_SRC_BATTERY;
      end else if (sync2_r[`CFFR_F_PGOOD] &&
                   rail_mode == `CFFR_RAIL_MODE_NORMAL &&
                   !(any_loop_w && supplement_cond)) begin
        system_rail_source_select <= `CFFR_SRC_INPUT;
      end else begin
        system_rail_source_select <= `CFFR_SRC_BATTERY;
      end
    end
  end

  cffr_int_pulse u_pulse (
    .clk(clk),
    .resetn(resetn),
    .trigger(int_req_r),
    .int_out(int_out),
    .int_oe(int_oe),
    .busy()
  );

endmodule // cffr_flags

`default_nettype wire

// *** verif/cffr_flags_chk_sva.sv ***
/* Checker on the cffr_flags ports.
   Assumes it is bound to cffr_flags. */
`timescale 1ns/1ps
`default_nettype none
module cffr_flags_chk (
  input wire clk,
  input wire resetn,
  input wire [11:0] int_mask,
  input wire [11:0] flag_read,
  input wire [11:0] flags,
  input wire input_good_state,
  input wire charger_enable,
  input wire [1:0] safety_timer_ctrl,
  input wire [1:0] system_rail_source_select,
  input wire int_out,
  input wire int_oe
);
  logic [11:0] keep_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) keep_r <= 12'h000;
    else keep_r <= flags & ~flag_read;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rise;
    !int_oe ##1 int_oe;
  endsequence
  a_pin_pull_low: assert property (int_oe |-> int_out == 1'b0)
    else $error("pin driven high");
  a_pulse_held: assert property (s_rise |=> int_oe [*8])
    else $error("pulse too short");
  a_flag_sticky: assert property ((flags & keep_r) == keep_r)
    else $error("flag lost");
  a_mask_silent: assert property
    ((int_mask == 12'hFFF) [*4] ##0 !int_oe |=> !int_oe)
    else $error("masked pulse");
  a_cold_pause: assert property ($rose(flags[10]) && input_good_state |->
    !charger_enable && safety_timer_ctrl == 2'h1) else $error("cold");
  a_ovp_battery: assert property ($rose(flags[7]) |-> !charger_enable
    && system_rail_source_select == 2'h1 && safety_timer_ctrl == 2'h2)
    else $error("ovp");
  a_ocp_open: assert property ($rose(flags[8]) && !input_good_state |->
    !charger_enable
    && system_rail_source_select == 2'h2) else $error("ocp");
  a_bad_input_stop: assert property (!input_good_state [*2] |->
    !charger_enable && safety_timer_ctrl == 2'h2) else $error("input");
endmodule // cffr_flags_chk
bind cffr_flags cffr_flags_chk cffr_flags_chk_i (.clk(clk), .resetn(resetn),
  .int_mask(int_mask), .flag_read(flag_read), .flags(flags),
  .input_good_state(input_good_state), .charger_enable(charger_enable),
  .safety_timer_ctrl(safety_timer_ctrl), .int_out(int_out),
  .system_rail_source_select(system_rail_source_select), .int_oe(int_oe));
`default_nettype wire

// *** verif/cffr_host_model.sv ***
/* Host model: reads every set flag once each interrupt pulse ends.
   Assumes the pin level with its pull-up is given on int_n. */
`timescale 1ns/1ps
`default_nettype none
module cffr_host_model (
  input wire clk,
  input wire resetn,
  input wire int_n,
  input wire [11:0] flags,
  output logic [11:0] flag_read
);
  logic int_n_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_n_r <= 1'b1;
      flag_read <= 12'h000;
    end else begin
      int_n_r <= int_n;
      // Reading only after the pulse keeps flags visible to the bench.
      flag_read <= (int_n && !int_n_r) ? flags : 12'h000;
    end
  end
endmodule // cffr_host_model
`default_nettype wire

// *** verif/tb_top.sv ***
/* Bench for cffr_flags with the host model on the interrupt pin.
   Assumes a 12800-cycle pulse. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++;\
 $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic clk = 0, resetn = 0;
  logic cv, dn, ii, dp, vd, th, good, ovp, ocp, uv, cold, cool, sup, rch;
  logic cen, str;
  logic [1:0] mode;
  logic [11:0] mask;
  wire [11:0] rd, flags;
  wire gst, en, dbl, iout, ioe;
  wire [1:0] tmr, rail;
  wire int_n = ioe ? iout : 1'b1;
  int n_errors = 0, comparisons = 0, cnt;
  always #5 clk = ~clk;
  cffr_flags cffr_flags_i (.clk(clk), .resetn(resetn), .cv_active(cv),
    .charge_done(dn), .iinlim_active(ii), .dynamic_power_path_loop_active(dp),
    .vindpm_active(vd), .therm_active(th), .input_good(good),
    .input_ovp(ovp), .bat_ocp(ocp), .bat_uvlo(uv), .ts_cold(cold),
    .ts_cool(cool), .supplement_cond(sup), .recharge_reached(rch),
    .charge_en_cfg(cen), .timer_stretch_en(str), .rail_mode(mode),
    .int_mask(mask), .flag_read(rd), .flags(flags),
    .input_good_state(gst), .charger_enable(en), .safety_timer_ctrl(tmr),
    .safety_timer_double(dbl), .system_rail_source_select(rail),
    .int_out(iout), .int_oe(ioe));
  cffr_host_model cffr_host_model_i (.clk(clk), .resetn(resetn),
    .int_n(int_n), .flags(flags), .flag_read(rd));
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task final_report();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic int_start();
    cnt = 0;
    while (!ioe && cnt < 10) begin
      tick(1);
      cnt++;
    end
    if (!ioe) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic int_end(int b);
    cnt = 0;
    while (ioe && cnt < 13000) begin
      tick(1);
      cnt++;
    end
    `CHK("pulse", 12800, cnt)
    tick(3);
    `CHK("clear", 1'b0, flags[b])
  endtask
  initial begin
    {cv, dn, ii, dp, vd, th, ovp, ocp, uv, cold, cool, sup, rch, str} = '0;
    good = 1;
    cen = 1;
    mode = 2'h0;
    mask = 12'h000;
    tick(5);
    @(posedge clk) resetn <= 1;
    tick(10);
    `CHK("en", 1'b1, en)
    `CHK("rail", 2'h0, rail)
    @(posedge clk) cold <= 1;
    int_start();
    `CHK("cold", 1'b1, flags[10])
    `CHK("cold tmr", 2'h1, tmr)
    `CHK("cold rail", 2'h0, rail)
    int_end(10);
    @(posedge clk) cold <= 0;
    @(posedge clk) begin str <= 1; dp <= 1; end
    int_start();
    `CHK("dynamic_power_path_loop en", 1'b1, en)
    `CHK("double", 1'b1, dbl)
    `CHK("dynamic_power_path_loop rail", 2'h0, rail)
    int_end(3);
    @(posedge clk) begin str <= 0; mask <= 12'h200; uv <= 1; end
    tick(8);
    `CHK("uvlo", 1'b1, flags[9])
    `CHK("uvlo int", 1'b0, ioe)
    `CHK("no double", 1'b0, dbl)
    @(posedge clk) mask <= 12'h000;
    tick(8);
    `CHK("unmask int", 1'b0, ioe)
    @(posedge clk) ovp <= 1;
    int_start();
    `CHK("ovp rail", 2'h1, rail)
    `CHK("ovp tmr", 2'h2, tmr)
    int_end(7);
    @(posedge clk) begin ovp <= 0; good <= 0; end
    int_start();
    `CHK("pg fall", 1'b1, flags[6])
    `CHK("pg en", 1'b0, en)
    int_end(6);
    @(posedge clk) ocp <= 1;
    int_start();
    `CHK("ocp rail", 2'h2, rail)
    int_end(8);
    @(posedge clk) begin ocp <= 0; good <= 1; end
    int_start();
    `CHK("pg rise", 1'b1, flags[6])
    int_end(6);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
